// File: link_ctrl_regs.sv
/*
 Serial link control register bank: enable, mode, multiframe
 length, software sync request and control byte, plus the link
 block controls they steer.
 Assumes the mode decoder supplies encoding, E, F and lane count
 for the current mode, and a mode limit from the restriction block.
*/
`timescale 1ns/1ns
// How it works
// - Enable bit 0 disables, 1 enables; resets 1
// - Disabled: block in reset, serializers down
// - Disabled: link block clocks gated off
// - Disabled: multiframe counter held in reset
// - Software disables link before other changes
// - Software sets calibration before enabling link
// - Software disables link before clearing calibration
// - Eight-bit mode field, reset value 0x02
// - Mode changes only with link, calibration off
// - Modes beyond restriction limit are refused
// - Length field is K minus one, reset 0x1f
// - Software programs only legal K per mode
// - 64b/66b modes: K is 256*E/F
// - Writing 0 requests sync; resets 1
// - Software request works with any sync source
// - Control byte fields, reset value 0x03
// - Lane map picks lower or upper lanes
// - Sync source: dedicated pin, timestamp, none
// - Sample format: offset binary or two's complement
// - Scrambler bit; 64b/66b always scrambles
module link_ctrl_regs (
	input wire logic core_clk,
	input wire logic reset_n,
	link_cfg_if.device bus,
	input wire logic mode_is_64b66b,
	input wire logic [7:0] mode_e,
	input wire logic [7:0] mode_f,
	input wire logic [4:0] mode_lane_count,
	input wire logic [7:0] mode_limit,
	output logic link_reset,
	output logic link_clock_enable,
	output logic multiframe_counter_reset,
	output logic [7:0] lane_power_down,
	output logic [7:0] link_mode,
	output logic [15:0] frames_per_multiframe,
	output logic whitening_active,
	output logic sample_format,
	output logic timestamp_receiver_enable,
	output logic sync_request
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_START = 3'b010,
		ST_RUN = 3'b100
	} link_state_e;

	typedef struct packed {
		link_state_e state;
		logic link_enable_bit;
		logic [7:0] link_mode;
		logic [7:0] frames_per_multiframe_m1;
		logic soft_sync_request_n;
		logic [4:0] link_control_byte;
		logic [7:0] rdata;
		logic rvalid;
		logic link_reset;
		logic clock_enable;
		logic counter_reset;
		logic [7:0] lane_pd;
		logic [15:0] k_eff;
		logic whiten;
		logic fmt;
		logic ts_rx_en;
		logic sync_req;
	} regs_state_s;

	regs_state_s q;
	regs_state_s d;
	logic merged_request;
	logic [15:0] k_from_mode;
	logic [7:0] readback;

	// ----------------------------------------
	// Sync source
	// ----------------------------------------
	sync_source_select sync_sel (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.sync_pin_n(bus.sync_pin_n),
		.timestamp_pin(bus.timestamp_pin),
		.select(q.link_control_byte[link_regs_pkg::CTRL_SEL_HI:link_regs_pkg::CTRL_SEL_LO]),
		.soft_sync_request_n(q.soft_sync_request_n),
		.request(merged_request)
	);

	// Multiframe length taken from the mode in 64b/66b modes
	always_comb begin
		k_from_mode = {8'h00, q.frames_per_multiframe_m1} + 16'h0001;
		if (mode_is_64b66b && (mode_f != 8'h00)) begin
			k_from_mode = ({8'h00, mode_e} * link_regs_pkg::K_SCALE_64B) / {8'h00, mode_f};
		end
	end

	// Register readback; reserved bits and unmapped addresses read zero
	always_comb begin
		readback = 8'h00;
		unique case (bus.reg_addr)
			link_regs_pkg::ADDR_ENABLE: readback = {7'h00, q.link_enable_bit};
			link_regs_pkg::ADDR_MODE: readback = q.link_mode;
			link_regs_pkg::ADDR_KM1: readback = q.frames_per_multiframe_m1;
			link_regs_pkg::ADDR_SYNC: readback = {7'h00, q.soft_sync_request_n};
			link_regs_pkg::ADDR_CTRL: readback = {3'h0, q.link_control_byte};
			default: readback = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.rvalid = bus.reg_read;
		d.rdata = bus.reg_read ? readback : 8'h00;
		// Register writes take effect at the next edge
		if (bus.reg_write) begin
			unique case (bus.reg_addr)
				link_regs_pkg::ADDR_ENABLE: d.link_enable_bit = bus.reg_wdata[0];
				link_regs_pkg::ADDR_MODE: begin
					if (bus.reg_wdata <= mode_limit) begin
						d.link_mode = bus.reg_wdata;
					end
				end
				link_regs_pkg::ADDR_KM1: d.frames_per_multiframe_m1 = bus.reg_wdata;
				link_regs_pkg::ADDR_SYNC: d.soft_sync_request_n = bus.reg_wdata[0];
				link_regs_pkg::ADDR_CTRL: begin
					d.link_control_byte = bus.reg_wdata[4:0] & link_regs_pkg::CTRL_USED_MASK[4:0];
				end
				default: d.link_enable_bit = q.link_enable_bit;
			endcase
		end
		// Link sequencing from the enable bit
		unique case (q.state)
			ST_OFF: begin
				if (q.link_enable_bit) begin
					d.state = ST_START;
				end
			end
			ST_START: begin
				d.state = q.link_enable_bit ? ST_RUN : ST_OFF;
			end
			ST_RUN: begin
				if (!q.link_enable_bit) begin
					d.state = ST_OFF;
				end
			end
		endcase
		// Capture the programmed configuration as the link starts
		if (q.state == ST_START) begin
			d.k_eff = k_from_mode;
			d.whiten = mode_is_64b66b | q.link_control_byte[link_regs_pkg::CTRL_SCR_BIT];
			d.fmt = q.link_control_byte[link_regs_pkg::CTRL_FMT_BIT];
			d.lane_pd = link_regs_pkg::LANES_UPPER_OFF;
			if (q.link_control_byte[link_regs_pkg::CTRL_MAP_BIT] &&
				(mode_lane_count <= link_regs_pkg::ALT_MAP_MAX_LANES)) begin
				d.lane_pd = link_regs_pkg::LANES_LOWER_OFF;
			end
		end
		// Disabled link: reset held, clocks gated, lanes and counter down
		if (!q.link_enable_bit) begin
			d.lane_pd = link_regs_pkg::LANES_ALL_OFF;
		end
		d.link_reset = (d.state != ST_RUN);
		d.clock_enable = q.link_enable_bit;
		d.counter_reset = ~q.link_enable_bit;
		d.ts_rx_en = (q.link_control_byte[link_regs_pkg::CTRL_SEL_HI:link_regs_pkg::CTRL_SEL_LO] ==
			link_regs_pkg::SYNC_SEL_TSTAMP);
		d.sync_req = merged_request & q.link_enable_bit;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q.state <= ST_OFF;
			q.link_enable_bit <= link_regs_pkg::RST_ENABLE[0];
			q.link_mode <= link_regs_pkg::RST_MODE;
			q.frames_per_multiframe_m1 <= link_regs_pkg::RST_KM1;
			q.soft_sync_request_n <= link_regs_pkg::RST_SYNC[0];
			q.link_control_byte <= link_regs_pkg::RST_CTRL[4:0];
			q.rdata <= 8'h00;
			q.rvalid <= 1'b0;
			q.link_reset <= 1'b1;
			q.clock_enable <= 1'b0;
			q.counter_reset <= 1'b1;
			q.lane_pd <= link_regs_pkg::LANES_ALL_OFF;
			q.k_eff <= 16'h0000;
			q.whiten <= 1'b0;
			q.fmt <= 1'b0;
			q.ts_rx_en <= 1'b0;
			q.sync_req <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.reg_rdata = q.rdata;
	assign bus.reg_rvalid = q.rvalid;
	assign link_reset = q.link_reset;
	assign link_clock_enable = q.clock_enable;
	assign multiframe_counter_reset = q.counter_reset;
	assign lane_power_down = q.lane_pd;
	assign link_mode = q.link_mode;
	assign frames_per_multiframe = q.k_eff;
	assign whitening_active = q.whiten;
	assign sample_format = q.fmt;
	assign timestamp_receiver_enable = q.ts_rx_en;
	assign sync_request = q.sync_req;
endmodule

// File: link_regs_pkg.sv
/*
 Constants shared by both ends of the serial link control bank:
 register addresses, reset values, field positions and codes.
 Assumes byte-wide registers on a 12-bit register address.
*/
package link_regs_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [11:0] ADDR_ENABLE = 12'h200;
	localparam logic [11:0] ADDR_MODE = 12'h201;
	localparam logic [11:0] ADDR_KM1 = 12'h202;
	localparam logic [11:0] ADDR_SYNC = 12'h203;
	localparam logic [11:0] ADDR_CTRL = 12'h204;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_ENABLE = 8'h01;
	localparam logic [7:0] RST_MODE = 8'h02;
	localparam logic [7:0] RST_KM1 = 8'h1f;
	localparam logic [7:0] RST_SYNC = 8'h01;
	localparam logic [7:0] RST_CTRL = 8'h03;
	// ----------------------------------------
	// Control byte fields
	// ----------------------------------------
	localparam int CTRL_SCR_BIT = 0;
	localparam int CTRL_FMT_BIT = 1;
	localparam int CTRL_SEL_LO = 2;
	localparam int CTRL_SEL_HI = 3;
	localparam int CTRL_MAP_BIT = 4;
	localparam logic [7:0] CTRL_USED_MASK = 8'h1f;
	// ----------------------------------------
	// Sync source codes, lane figures and 64b/66b K scale
	// ----------------------------------------
	localparam logic [1:0] SYNC_SEL_PIN = 2'h0;
	localparam logic [1:0] SYNC_SEL_TSTAMP = 2'h1;
	localparam logic [1:0] SYNC_SEL_SOFT = 2'h2;
	localparam logic [4:0] ALT_MAP_MAX_LANES = 5'h08;
	localparam logic [7:0] LANES_LOWER_OFF = 8'h0f;
	localparam logic [7:0] LANES_UPPER_OFF = 8'hf0;
	localparam logic [7:0] LANES_ALL_OFF = 8'hff;
	localparam logic [15:0] K_SCALE_64B = 16'h0100;
endpackage

// File: link_cfg_if.sv
/*
 Carrier between the configuring host and the link register bank.
 Assumes both ends share core_clk; the testbench joins them.
*/
`timescale 1ns/1ns
interface link_cfg_if;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic cal_enable;
	logic sync_pin_n;
	logic timestamp_pin;

	modport device (
		input reg_addr, reg_wdata, reg_write, reg_read, cal_enable, sync_pin_n, timestamp_pin,
		output reg_rdata, reg_rvalid
	);
	modport host (
		output reg_addr, reg_wdata, reg_write, reg_read, cal_enable, sync_pin_n, timestamp_pin,
		input reg_rdata, reg_rvalid
	);
endinterface

// File: sync_source_select.sv
/*
 Sync request source: synchronises both sync pins and merges them
 with the software request according to the selected source.
 Assumes pins are asynchronous to core_clk and active low.
*/
`timescale 1ns/1ns
module sync_source_select (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic sync_pin_n,
	input wire logic timestamp_pin,
	input wire logic [1:0] select,
	input wire logic soft_sync_request_n,
	output logic request
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] pins;
	} sel_state_s;

	sel_state_s q;
	sel_state_s d;

	// Two flops per pin before anything reads the level
	always_comb begin
		d = q;
		d.meta = {sync_pin_n, timestamp_pin};
		d.pins = q.meta;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	// Software request always counts; a pin only when selected
	always_comb begin
		request = ~soft_sync_request_n;
		if (select == link_regs_pkg::SYNC_SEL_PIN) begin
			request = request | ~q.pins[1];
		end else if (select == link_regs_pkg::SYNC_SEL_TSTAMP) begin
			request = request | ~q.pins[0];
		end
	end
endmodule

// File: link_cfg_host.sv
/*
 Configuring host: runs the enable and calibration ordering when
 loading or stopping the link, forwards software sync and reads.
 Assumes one command at a time while busy is low.
*/
`timescale 1ns/1ns
module link_cfg_host (
	input wire logic core_clk,
	input wire logic reset_n,
	link_cfg_if.host bus,
	input wire logic cfg_start,
	input wire logic cfg_stop,
	input wire logic [7:0] cfg_mode,
	input wire logic [7:0] cfg_km1,
	input wire logic [7:0] cfg_ctrl,
	input wire logic soft_sync,
	input wire logic rx_sync_n,
	input wire logic rx_timestamp,
	input wire logic rd_start,
	input wire logic [11:0] rd_addr,
	output logic busy,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	typedef enum logic [8:0] {
		H_IDLE = 9'h001, H_DIS = 9'h002, H_UNCAL = 9'h004, H_MODE = 9'h008, H_KM1 = 9'h010,
		H_CTRL = 9'h020, H_CAL = 9'h040, H_EN = 9'h080, H_READ = 9'h100
	} host_state_e;

	typedef struct packed {
		host_state_e state;
		logic stopping;
		logic cal;
		logic sync_sent;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
		logic [7:0] rd_data;
		logic rd_valid;
		logic busy;
		logic pin_sync_n;
		logic pin_tstamp;
	} host_s;

	host_s q;
	host_s d;

	// Sequencer; disable first, calibration off around mode changes
	always_comb begin
		d = q;
		d.write = 1'b0;
		d.read = 1'b0;
		d.rd_valid = 1'b0;
		d.pin_sync_n = rx_sync_n;
		d.pin_tstamp = rx_timestamp;
		unique case (q.state)
			H_IDLE: begin
				if (cfg_start || cfg_stop) begin
					d.state = H_DIS;
					d.stopping = cfg_stop;
				end else if (rd_start) begin
					d.state = H_READ;
				end else if (soft_sync != q.sync_sent) begin
					d.sync_sent = soft_sync;
					d.write = 1'b1;
					d.addr = link_regs_pkg::ADDR_SYNC;
					d.wdata = {7'h00, ~soft_sync};
				end
			end
			H_DIS: d.state = H_UNCAL;
			H_UNCAL: d.state = q.stopping ? H_IDLE : H_MODE;
			H_MODE: d.state = H_KM1;
			H_KM1: d.state = H_CTRL;
			H_CTRL: d.state = H_CAL;
			H_CAL: d.state = H_EN;
			H_EN: d.state = H_IDLE;
			H_READ: begin
				if (bus.reg_rvalid) begin
					d.state = H_IDLE;
					d.rd_data = bus.reg_rdata;
					d.rd_valid = 1'b1;
				end
			end
		endcase
		// Bus action for the state being entered
		unique case (d.state)
			H_DIS: begin
				d.write = 1'b1;
				d.addr = link_regs_pkg::ADDR_ENABLE;
				d.wdata = 8'h00;
			end
			H_UNCAL: d.cal = 1'b0;
			H_MODE: begin
				d.write = 1'b1;
				d.addr = link_regs_pkg::ADDR_MODE;
				d.wdata = cfg_mode;
			end
			H_KM1: begin
				d.write = 1'b1;
				d.addr = link_regs_pkg::ADDR_KM1;
				d.wdata = cfg_km1;
			end
			H_CTRL: begin
				d.write = 1'b1;
				d.addr = link_regs_pkg::ADDR_CTRL;
				d.wdata = cfg_ctrl;
			end
			H_CAL: d.cal = 1'b1;
			H_EN: begin
				d.write = 1'b1;
				d.addr = link_regs_pkg::ADDR_ENABLE;
				d.wdata = link_regs_pkg::RST_ENABLE;
			end
			H_READ: begin
				d.read = (q.state == H_IDLE);
				d.addr = (q.state == H_IDLE) ? rd_addr : q.addr;
			end
			default: d.cal = d.cal;
		endcase
		d.busy = (d.state != H_IDLE);
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q.state <= H_IDLE;
			q.stopping <= 1'b0;
			q.cal <= 1'b0;
			q.sync_sent <= 1'b0;
			q.addr <= 12'h000;
			q.wdata <= 8'h00;
			q.write <= 1'b0;
			q.read <= 1'b0;
			q.rd_data <= 8'h00;
			q.rd_valid <= 1'b0;
			q.busy <= 1'b0;
			q.pin_sync_n <= 1'b1;
			q.pin_tstamp <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign bus.reg_addr = q.addr;
	assign bus.reg_wdata = q.wdata;
	assign bus.reg_write = q.write;
	assign bus.reg_read = q.read;
	assign bus.cal_enable = q.cal;
	assign bus.sync_pin_n = q.pin_sync_n;
	assign bus.timestamp_pin = q.pin_tstamp;
	assign busy = q.busy;
	assign rd_data = q.rd_data;
	assign rd_valid = q.rd_valid;
endmodule

// File: link_regs_chk.sv
/*
 Checker for the register carrier between host and link bank.
 Assumes the testbench wires it to the carrier signals by name.
*/
`timescale 1ns/1ns
module link_regs_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic cal_enable,
	input wire logic sync_pin_n,
	input wire logic timestamp_pin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Shadow registers
	// ----------------------------------------
	logic en_q;
	logic sync_q;
	logic [7:0] len_q;
	// Follow writes to enable, length and sync registers
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			en_q <= 1'b1;
			sync_q <= 1'b1;
			len_q <= 8'h1f;
		end else if (reg_write) begin
			if (reg_addr == 12'h200) en_q <= reg_wdata[0];
			if (reg_addr == 12'h203) sync_q <= reg_wdata[0];
			if (reg_addr == 12'h202) len_q <= reg_wdata;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_cfg_quiet;
		reg_write && reg_addr inside {12'h201, 12'h202, 12'h204} |-> !en_q;
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("config write while link enabled");
	property p_cal_first;
		reg_write && reg_addr == 12'h200 && reg_wdata[0] |-> cal_enable;
	endproperty
	a_cal_first: assert property (p_cal_first) else $error("link enabled without calibration");
	property p_cal_last;
		$fell(cal_enable) |-> !en_q;
	endproperty
	a_cal_last: assert property (p_cal_last) else $error("calibration cleared while enabled");
	property p_mode_quiet;
		reg_write && reg_addr == 12'h201 |-> !cal_enable && !en_q;
	endproperty
	a_mode_quiet: assert property (p_mode_quiet) else $error("mode write while active");
	property p_en_read;
		reg_read && reg_addr == 12'h200 |=> reg_rvalid && reg_rdata == {7'h00, $past(en_q)};
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable readback wrong");
	property p_len_read;
		reg_read && reg_addr == 12'h202 |=> reg_rvalid && reg_rdata == $past(len_q);
	endproperty
	a_len_read: assert property (p_len_read) else $error("length readback wrong");
	property p_sync_read;
		reg_read && reg_addr == 12'h203 |=> reg_rvalid && reg_rdata == {7'h00, $past(sync_q)};
	endproperty
	a_sync_read: assert property (p_sync_read) else $error("sync readback wrong");
	property p_ctrl_rsvd;
		reg_read && reg_addr == 12'h204 |=> reg_rvalid && reg_rdata[7:5] == 3'h0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits set");
	c_enable: cover property (reg_write && reg_addr == 12'h200 && reg_wdata[0]);
	c_mode: cover property (reg_write && reg_addr == 12'h201);
	c_ctrl_read: cover property (reg_read && reg_addr == 12'h204);
endmodule

// File: serial_link_control_regs_tb.sv
/*
 Testbench joining host and link bank through the carrier.
 Assumes the host orders enable and calibration by itself.
*/
`timescale 1ns/1ns
module serial_link_control_regs_tb;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cfg_start = 1'b0, cfg_stop = 1'b0, soft_sync = 1'b0, rd_start = 1'b0;
	logic rx_sync_n = 1'b1, rx_timestamp = 1'b1, is64 = 1'b0;
	logic [7:0] cfg_mode = 8'h00, cfg_km1 = 8'h00, cfg_ctrl = 8'h00;
	logic [7:0] mode_e = 8'h01, mode_f = 8'h01, mode_limit = 8'hff;
	logic [4:0] lanes = 5'h04;
	logic [11:0] rd_addr = 12'h000;
	logic busy, rd_valid, link_reset, clk_en, cnt_rst, whiten, fmt, ts_en, sync_req;
	logic [7:0] rd_data, lane_pd, link_mode, e_v, f_v, lim, md, km, ctl, exp_mode;
	logic [15:0] k_eff;
	logic [31:0] rv, rv2;
	int err_count = 0;
	int n_tests = 0;
	int seed = 32'h48ed400c;
	// Free running clock
	always #10 core_clk = ~core_clk;
	link_cfg_if bus_if ();
	link_ctrl_regs i_link_ctrl_regs (.core_clk(core_clk), .reset_n(reset_n), .bus(bus_if),
		.mode_is_64b66b(is64), .mode_e(mode_e), .mode_f(mode_f), .mode_lane_count(lanes),
		.mode_limit(mode_limit), .link_reset(link_reset), .link_clock_enable(clk_en),
		.multiframe_counter_reset(cnt_rst), .lane_power_down(lane_pd), .link_mode(link_mode),
		.frames_per_multiframe(k_eff), .whitening_active(whiten), .sample_format(fmt),
		.timestamp_receiver_enable(ts_en), .sync_request(sync_req));
	link_cfg_host i_link_cfg_host (.core_clk(core_clk), .reset_n(reset_n), .bus(bus_if),
		.cfg_start(cfg_start), .cfg_stop(cfg_stop), .cfg_mode(cfg_mode), .cfg_km1(cfg_km1),
		.cfg_ctrl(cfg_ctrl), .soft_sync(soft_sync), .rx_sync_n(rx_sync_n), .rx_timestamp(rx_timestamp),
		.rd_start(rd_start), .rd_addr(rd_addr), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid));
	link_regs_chk i_link_regs_chk (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(bus_if.reg_addr),
		.reg_wdata(bus_if.reg_wdata), .reg_write(bus_if.reg_write), .reg_read(bus_if.reg_read),
		.reg_rdata(bus_if.reg_rdata), .reg_rvalid(bus_if.reg_rvalid), .cal_enable(bus_if.cal_enable),
		.sync_pin_n(bus_if.sync_pin_n), .timestamp_pin(bus_if.timestamp_pin));
	// ----------------------------------------
	// Expectation functions
	// ----------------------------------------
	function automatic logic [15:0] exp_k(input logic m64, input logic [7:0] e, f, k);
		return m64 ? ({e, 8'h00} / {8'h00, f}) : {8'h00, k} + 16'h0001;
	endfunction
	function automatic logic [7:0] exp_lanes(input logic upper, input logic [4:0] n);
		return (upper && n <= 5'h08) ? 8'h0f : 8'hf0;
	endfunction
	function automatic logic exp_sync(input logic [1:0] sel, input logic pin, ts);
		return (sel == 2'h0 && !pin) || (sel == 2'h1 && !ts);
	endfunction
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic run_cmd(input logic stop);
		int n;
		@(posedge core_clk);
		cfg_start <= !stop;
		cfg_stop <= stop;
		@(posedge core_clk);
		cfg_start <= 1'b0;
		cfg_stop <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 40);
		chk("cmd_done", {15'h0000, busy}, 16'h0000);
		repeat (5) @(posedge core_clk);
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		int n;
		@(posedge core_clk);
		rd_addr <= a;
		rd_start <= 1'b1;
		@(posedge core_clk);
		rd_start <= 1'b0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(name, {7'h00, rd_valid, rd_data}, {8'h01, exp});
	endtask
	task automatic settle_sync;
		repeat (8) @(posedge core_clk);
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#400000;
		err_count++;
		stop_test;
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		chk("run_reset", {link_reset, clk_en, cnt_rst}, 3'b010);
		chk("k", k_eff, 16'h0020);
		chk("lanes", lane_pd, 8'hf0);
		chk("fmt_scr", {whiten, fmt}, 2'h3);
		rd(12'h200, 8'h01, "enable");
		rd(12'h201, 8'h02, "mode");
		rd(12'h202, 8'h1f, "length");
		rd(12'h203, 8'h01, "sync");
		rd(12'h204, 8'h03, "ctrl");
		rd(12'h205, 8'h00, "unmapped");
		exp_mode = 8'h02;
		for (int i = 0; i < 8; i++) begin
			run_cmd(1'b1);
			chk("off", {link_reset, clk_en, cnt_rst, lane_pd, sync_req}, {3'b101, 8'hff, 1'b0});
			rd(12'h200, 8'h00, "enable_off");
			rv = $random(seed);
			rv2 = $random(seed);
			e_v = {4'h0, rv[4:1]} + 8'h01;
			f_v = {4'h0, rv[8:5]} + 8'h01;
			lim = {2'h0, rv[14:9]};
			md = (i == 0) ? lim + 8'h01 : {2'h0, rv[20:15]};
			km = rv[28:21];
			ctl = rv2[7:0];
			if (ctl[3:2] == 2'h3) ctl[3] = 1'b0;
			if (i == 1) ctl[3:2] = 2'h2;
			@(posedge core_clk);
			is64 <= rv[0];
			mode_e <= e_v;
			mode_f <= f_v;
			mode_limit <= lim;
			lanes <= rv2[12:8];
			cfg_mode <= md;
			cfg_km1 <= km;
			cfg_ctrl <= ctl;
			run_cmd(1'b0);
			if (md <= lim) exp_mode = md;
			chk("on", {link_reset, clk_en, cnt_rst}, 3'b010);
			rd(12'h201, exp_mode, "mode");
			rd(12'h202, km, "length");
			rd(12'h204, ctl & 8'h1f, "ctrl");
			chk("link_mode", {8'h00, link_mode}, {8'h00, exp_mode});
			chk("k", k_eff, exp_k(is64, e_v, f_v, km));
			chk("lanes", {8'h00, lane_pd}, {8'h00, exp_lanes(ctl[4], lanes)});
			chk("fmt", {15'h0000, fmt}, {15'h0000, ctl[1]});
			chk("scr", {15'h0000, whiten}, {15'h0000, ctl[0] | is64});
			chk("ts_en", {15'h0000, ts_en}, {15'h0000, ctl[3:2] == 2'h1});
			@(posedge core_clk);
			rx_sync_n <= rv2[13] && i != 1;
			rx_timestamp <= rv2[14] && i != 1;
			settle_sync;
			chk("sync_pin", {15'h0000, sync_req}, {15'h0000, exp_sync(ctl[3:2], rx_sync_n, rx_timestamp)});
			@(posedge core_clk);
			soft_sync <= 1'b1;
			settle_sync;
			chk("sync_soft", {15'h0000, sync_req}, 16'h0001);
			rd(12'h203, 8'h00, "sync_reg");
			@(posedge core_clk);
			soft_sync <= 1'b0;
			rx_sync_n <= 1'b1;
			rx_timestamp <= 1'b1;
		end
		stop_test;
	end
endmodule
